// ===== core/aid_defines.svh
/*
 Constants for the accessory impedance detect controller: register indices,
 field positions, reset values and timing figures.
 Assumes a 200 MHz bus clock and a 32 kHz measurement time base.
*/
`ifndef AID_DEFINES_SVH
`define AID_DEFINES_SVH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define AID_IDX_MODE        10'h293
`define AID_IDX_TIMING      10'h2A3
`define AID_IDX_LVL_EN      10'h2A4
`define AID_IDX_LVL_RES     10'h2A5
`define AID_IDX_ADC_RES     10'h2AB
`define AID_IDX_CLAMP       10'h2C6

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define AID_F_PIN_SEL       13
`define AID_F_MODE_LO       0
`define AID_F_SETTLE_LO     12
`define AID_F_RATE_LO       8
`define AID_F_REF_LO        4
`define AID_F_DB_SEL        1
`define AID_F_ENA           0
`define AID_F_LVL_LO        2
`define AID_F_VALID         1
`define AID_F_PRESENT       0
`define AID_F_DELTA_LO      8
`define AID_F_OVD           4

// ---------------------------------------------------------------
// Codes and reset values
// ---------------------------------------------------------------
`define AID_MODE_DISCRETE   3'h0
`define AID_MODE_HP_LEFT    3'h1
`define AID_MODE_HP_RIGHT   3'h2
`define AID_MODE_HP_SENSE   3'h4
`define AID_MODE_ADC        3'h7
`define AID_RST_MODE        3'h0
`define AID_RST_PIN_SEL     1'h0
`define AID_RST_SETTLE      4'h1
`define AID_RST_RATE        4'h1
`define AID_RST_REF         3'h0
`define AID_RST_DB_SEL      1'h1
`define AID_RST_ENA         1'h0
`define AID_RST_LVL_EN      8'h9F
`define AID_RST_OVD         1'h1
`define AID_RST_CLAMP_COND  4'h0
`define AID_CODE_CAP        4'hC
`define AID_RESP_OKAY       2'h0
`define AID_RESP_SLVERR     2'h2

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define AID_CLK_HZ          200000000
`define AID_TICK_HZ         32000
`define AID_DELAY_BASE_MS   0.25
`define AID_DELAY_BASE_TICKS (`AID_DELAY_BASE_MS * `AID_TICK_HZ / 1000.0)
`define AID_TICK_DIV        (`AID_CLK_HZ / `AID_TICK_HZ)

`endif

// ===== core/aid_detect_ctrl.sv
/*
 Accessory and microphone impedance detect controller: AXI4-Lite register
 file, measurement scheduler on a 32 kHz tick, bias auto-enable, debounce,
 level folding, ADC result capture, events and clamp control.
 Assumes an analog front end that holds level/adc stable while done is high
 and drops done after start falls; bias_on_i comes from logic on aclk.
*/
//
// Notes on behaviour
// R1: mode codes pick discrete, headphone, ADC detect
// R2: pin select bit routes sense and feedback
// R3: detection runs only enabled in mode 000/111
// R4: repeat measurements with coded gap delay
// R5: switch bias on per measurement if off
// R6: wait coded start-up delay after bias on
// R7: reference select: rail or bias one-three
// R8: accept level after 2 or 4 matches
// R9: valid stays set while detection enabled
// R10: level and presence update while valid held
// R11: one-hot nine-bit level field at 10:2
// R12: level enable mask per impedance level
// R13: software writes zero to mask bits 6,5
// R14: disabled level reports next lower enabled
// R15: ADC mode gives seven-bit result
// R16: software clears enable before reading ADC
// R17: hold latest ADC value and its delta
// R18: ADC delta 15:8, value 6:0
// R19: valid bit 1, presence bit 0
// R20: events on insertion, removal, impedance change
// R21: software runs one detection at once
// R22: software keeps clock and bias supply up
// R23: removal raises event and asserts clamp
// R24: software clears override before enabling detect
// R25: software sets override after removal cleanup
// R26: override forces clamp, set after reset
// R27: scheduler counts 32 kHz ticks, idles disabled
`timescale 1ns/1ps
`include "aid_defines.svh"

module aid_detect_ctrl
	import aid_pkg::*;
#(
	parameter int TICK_DIV = `AID_TICK_DIV
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [11:0]  s_axi_awaddr,
	input  wire logic [2:0]   s_axi_awprot,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [11:0]  s_axi_araddr,
	input  wire logic [2:0]   s_axi_arprot,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready,
	input  wire aid_ana_in_t  ana_i,
	input  wire logic [2:0]   bias_on_i,
	output aid_ana_out_t      ana_o,
	output logic              fb_pin_b,
	output logic              clamp_active,
	output logic [3:0]        clamp_condition_select,
	output logic              evt_insert,
	output logic              evt_remove,
	output logic              evt_change
);

	localparam int          BASE_TICKS = int'(`AID_DELAY_BASE_TICKS);
	localparam logic [12:0] PRE_LAST   = 13'(TICK_DIV - 1);

	aid_st_t q;
	aid_st_t d;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// R4 R6 shared delay code to tick count
	function automatic logic [14:0] aid_ticks(input logic [3:0] c);
		logic [14:0] t;
		t = 15'h0000;
		if (c >= `AID_CODE_CAP) begin
			t = 15'(BASE_TICKS << 11);
		end else if (c != 4'h0) begin
			t = 15'(BASE_TICKS << (c - 4'h1));
		end
		return t;
	endfunction

	// R14 fold to next lower enabled level
	function automatic logic [8:0] aid_fold(input logic [8:0] raw, input logic [7:0] m);
		logic [8:0] en;
		logic [8:0] r;
		logic       hit;
		en  = {m[7], 2'b00, m[4:0], 1'b1};
		r   = 9'h000;
		hit = 1'b0;
		for (int i = 8; i >= 0; i--) begin
			if (raw[i]) begin
				hit = 1'b1;
			end
			if (hit && en[i] && (r == 9'h000)) begin
				r[i] = 1'b1;
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] aid_rd(input aid_st_t s, input logic [9:0] idx);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (idx)
			`AID_IDX_MODE: begin
				v[`AID_F_PIN_SEL] = s.pin_sel;
				v[`AID_F_MODE_LO +: 3] = s.mode;
			end
			`AID_IDX_TIMING: begin
				v[`AID_F_SETTLE_LO +: 4] = s.settle_code;
				v[`AID_F_RATE_LO +: 4]   = s.rate_code;
				v[`AID_F_REF_LO +: 3]    = s.ref_sel;
				v[`AID_F_DB_SEL]         = s.db_sel;
				v[`AID_F_ENA]            = s.ena;
			end
			`AID_IDX_LVL_EN: begin
				v[7:0] = s.lvl_mask;
			end
			// R19 valid and presence bits
			`AID_IDX_LVL_RES: begin
				v[`AID_F_LVL_LO +: 9] = s.level;
				v[`AID_F_VALID]       = s.valid;
				v[`AID_F_PRESENT]     = s.present;
			end
			// R18 ADC delta and value layout
			`AID_IDX_ADC_RES: begin
				v[`AID_F_DELTA_LO +: 8] = s.adc_delta;
				v[6:0]                  = s.adc;
			end
			`AID_IDX_CLAMP: begin
				v[`AID_F_OVD] = s.clamp_ovd;
				v[3:0]        = s.clamp_cond;
			end
			default: begin
				v = 32'h0000_0000;
			end
		endcase
		return v;
	endfunction

	function automatic logic aid_mapped(input logic [11:0] a);
		logic [9:0] i;
		i = a[11:2];
		return (a[1:0] == 2'b00) && ((i == `AID_IDX_MODE) || (i == `AID_IDX_TIMING) ||
			(i == `AID_IDX_LVL_EN) || (i == `AID_IDX_LVL_RES) ||
			(i == `AID_IDX_ADC_RES) || (i == `AID_IDX_CLAMP));
	endfunction

	logic        run;
	logic        need_bias;
	logic        done_rise;
	logic [8:0]  folded;
	logic [2:0]  db_next;
	logic        accept;
	logic [14:0] rate_ticks;
	logic [14:0] settle_ticks;

	// R3 run only when enabled in a mic mode
	assign run = q.ena && ((q.mode == `AID_MODE_DISCRETE) || (q.mode == `AID_MODE_ADC));

	// R5 R7 auto bias only for an idle bias output
	always_comb begin
		case (q.ref_sel)
			3'h1:    need_bias = ~bias_on_i[0];
			3'h2:    need_bias = ~bias_on_i[1];
			3'h3:    need_bias = ~bias_on_i[2];
			default: need_bias = 1'b0;
		endcase
	end

	assign done_rise    = q.sync2[16] & ~q.done_prev;
	assign folded       = aid_fold(q.sync2[15:7], q.lvl_mask);
	assign rate_ticks   = aid_ticks(q.rate_code);
	assign settle_ticks = aid_ticks(q.settle_code);
	// R8 count successive identical results
	assign db_next = ((folded == q.cand) && (q.db_cnt != 3'h0)) ?
		((q.db_cnt == 3'h4) ? 3'h4 : q.db_cnt + 3'h1) : 3'h1;
	assign accept  = db_next >= (q.db_sel ? 3'h4 : 3'h2);

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		d = q;
		d.tick    = 1'b0;
		d.evt_ins = 1'b0;
		d.evt_rem = 1'b0;
		d.evt_chg = 1'b0;
		d.sync1     = {ana_i.done, ana_i.level, ana_i.adc};
		d.sync2     = q.sync1;
		d.done_prev = q.sync2[16];

		// R27 32 kHz tick from the bus clock
		if (q.pre == PRE_LAST) begin
			d.pre  = 13'h0000;
			d.tick = 1'b1;
		end else begin
			d.pre = q.pre + 13'h0001;
		end

		case (q.state)
			AID_IDLE: begin
				if (run && need_bias) begin
					d.state    = AID_SETTLE;
					d.dcnt     = settle_ticks;
					d.bias_req = 1'b1;
				end else if (run) begin
					d.state = AID_MEAS;
					d.start = 1'b1;
				end
			end
			// R6 bias start-up wait
			AID_SETTLE: begin
				if (q.dcnt == 15'h0000) begin
					d.state = AID_MEAS;
					d.start = 1'b1;
				end else if (q.tick) begin
					d.dcnt = q.dcnt - 15'h0001;
				end
			end
			AID_MEAS: begin
				if (done_rise) begin
					d.start    = 1'b0;
					d.bias_req = 1'b0;
					d.state    = AID_GAP;
					// R4 gap after each measurement
					d.dcnt     = rate_ticks;
					if (q.mode == `AID_MODE_DISCRETE) begin
						d.cand   = folded;
						d.db_cnt = db_next;
						if (accept) begin
							// R20 events from accepted results
							if (!q.valid) begin
								d.evt_ins = |folded;
							end else if (q.present != (|folded)) begin
								d.evt_ins = |folded;
								d.evt_rem = ~(|folded);
							end else if (q.level != folded) begin
								d.evt_chg = 1'b1;
							end
							// R10 R11 update level and presence
							d.level   = folded;
							d.present = |folded;
							// R9 valid once settled
							d.valid   = 1'b1;
						end
					end else begin
						// R15 R17 latest value and delta
						d.adc       = q.sync2[6:0];
						d.adc_delta = 8'({1'b0, q.sync2[6:0]} - {1'b0, q.adc});
						d.adc_seen  = 1'b1;
						d.valid     = q.adc_seen;
					end
				end
			end
			AID_GAP: begin
				if (q.dcnt == 15'h0000) begin
					if (need_bias) begin
						d.state    = AID_SETTLE;
						d.dcnt     = settle_ticks;
						d.bias_req = 1'b1;
					end else begin
						d.state = AID_MEAS;
						d.start = 1'b1;
					end
				end else if (q.tick) begin
					d.dcnt = q.dcnt - 15'h0001;
				end
			end
			default: begin
				d.state = AID_IDLE;
			end
		endcase

		// R3 R27 hold idle while disabled
		if (!run) begin
			d.state    = AID_IDLE;
			d.start    = 1'b0;
			d.bias_req = 1'b0;
			d.valid    = 1'b0;
			d.db_cnt   = 3'h0;
			d.adc_seen = 1'b0;
		end

		// ---------------- AXI4-Lite slave ----------------
		if (s_axi_awvalid && q.awready) begin
			d.aw_have = 1'b1;
			d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && q.wready) begin
			d.w_have = 1'b1;
			d.wdata  = s_axi_wdata;
			d.wstrb  = s_axi_wstrb;
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		if (q.aw_have && q.w_have && !q.bvalid) begin
			d.aw_have = 1'b0;
			d.w_have  = 1'b0;
			d.bvalid  = 1'b1;
			d.bresp   = aid_mapped(q.aw_addr) ? `AID_RESP_OKAY : `AID_RESP_SLVERR;
			if (aid_mapped(q.aw_addr)) begin
				case (q.aw_addr[11:2])
					`AID_IDX_MODE: begin
						// R1 R2 mode and pin select
						if (q.wstrb[0]) d.mode = q.wdata[`AID_F_MODE_LO +: 3];
						if (q.wstrb[1]) d.pin_sel = q.wdata[`AID_F_PIN_SEL];
					end
					`AID_IDX_TIMING: begin
						if (q.wstrb[0]) begin
							d.ref_sel = q.wdata[`AID_F_REF_LO +: 3];
							d.db_sel  = q.wdata[`AID_F_DB_SEL];
							d.ena     = q.wdata[`AID_F_ENA];
						end
						if (q.wstrb[1]) begin
							d.settle_code = q.wdata[`AID_F_SETTLE_LO +: 4];
							d.rate_code   = q.wdata[`AID_F_RATE_LO +: 4];
						end
					end
					// R12 level enable mask
					`AID_IDX_LVL_EN: begin
						if (q.wstrb[0]) d.lvl_mask = q.wdata[7:0];
					end
					`AID_IDX_CLAMP: begin
						if (q.wstrb[0]) begin
							d.clamp_ovd  = q.wdata[`AID_F_OVD];
							d.clamp_cond = q.wdata[3:0];
						end
					end
					default: begin
						d.bresp = `AID_RESP_OKAY;
					end
				endcase
			end
		end
		d.awready = !d.aw_have && !d.bvalid;
		d.wready  = !d.w_have && !d.bvalid;

		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && q.arready) begin
			d.rvalid = 1'b1;
			d.rdata  = aid_mapped(s_axi_araddr) ? aid_rd(q, s_axi_araddr[11:2]) : 32'h0000_0000;
			d.rresp  = aid_mapped(s_axi_araddr) ? `AID_RESP_OKAY : `AID_RESP_SLVERR;
		end
		d.arready = !d.rvalid;

		// R23 removal sets the clamp, insertion releases it
		if (d.evt_rem) begin
			d.clamp_auto = 1'b1;
		end else if (d.evt_ins) begin
			d.clamp_auto = 1'b0;
		end
		// R26 override forces the clamp
		d.clamp_active = d.clamp_ovd | d.clamp_auto;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q             <= '0;
			q.mode        <= `AID_RST_MODE;
			q.pin_sel     <= `AID_RST_PIN_SEL;
			q.settle_code <= `AID_RST_SETTLE;
			q.rate_code   <= `AID_RST_RATE;
			q.ref_sel     <= `AID_RST_REF;
			q.db_sel      <= `AID_RST_DB_SEL;
			q.ena         <= `AID_RST_ENA;
			q.lvl_mask    <= `AID_RST_LVL_EN;
			// R26 clamp active after reset
			q.clamp_ovd    <= `AID_RST_OVD;
			q.clamp_active <= `AID_RST_OVD;
			q.clamp_cond   <= `AID_RST_CLAMP_COND;
			q.state        <= AID_IDLE;
		end else begin
			q <= d;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign s_axi_awready = q.awready;
	assign s_axi_wready  = q.wready;
	assign s_axi_bvalid  = q.bvalid;
	assign s_axi_bresp   = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid  = q.rvalid;
	assign s_axi_rdata   = q.rdata;
	assign s_axi_rresp   = q.rresp;
	// R2 R7 routing straight from register bits
	assign ana_o         = '{start: q.start, bias_req: q.bias_req, ref_sel: q.ref_sel,
	                         mode: q.mode, pin_b: q.pin_sel};
	assign fb_pin_b      = q.pin_sel;
	assign clamp_active  = q.clamp_active;
	assign clamp_condition_select = q.clamp_cond;
	assign evt_insert    = q.evt_ins;
	assign evt_remove    = q.evt_rem;
	assign evt_change    = q.evt_chg;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_idle_when_off;
		!run |=> (q.state == AID_IDLE) && !q.start && !q.bias_req;
	endproperty
	a_idle_when_off: assert property (p_idle_when_off) else $error("active while off"); // R3

	property p_reserved_mode;
		(q.mode == 3'h3 || q.mode == 3'h5 || q.mode == 3'h6) |=> q.state == AID_IDLE;
	endproperty
	a_reserved_mode: assert property (p_reserved_mode) else $error("ran in bad mode"); // R1

	property p_gap_load;
		(q.state == AID_MEAS) && done_rise && run |=>
			(q.state == AID_GAP) && (q.dcnt == aid_ticks($past(q.rate_code)));
	endproperty
	a_gap_load: assert property (p_gap_load) else $error("gap count wrong"); // R4

	property p_settle_bias;
		(q.state == AID_SETTLE) |-> q.bias_req && !q.start;
	endproperty
	a_settle_bias: assert property (p_settle_bias) else $error("no bias in settle"); // R5

	property p_settle_load;
		$rose(q.state == AID_SETTLE) |-> q.dcnt == aid_ticks($past(q.settle_code));
	endproperty
	a_settle_load: assert property (p_settle_load) else $error("settle count wrong"); // R6

	property p_debounce;
		$rose(q.valid) && (q.mode == `AID_MODE_DISCRETE) |->
			q.db_cnt >= ($past(q.db_sel) ? 3'h4 : 3'h2);
	endproperty
	a_debounce: assert property (p_debounce) else $error("accepted too early"); // R8

	property p_valid_hold;
		q.valid && run ##1 run |-> q.valid;
	endproperty
	a_valid_hold: assert property (p_valid_hold) else $error("valid dropped"); // R9

	property p_onehot;
		$onehot0(q.level) && !q.level[6] && !q.level[7];
	endproperty
	a_onehot: assert property (p_onehot) else $error("level not one-hot"); // R11

	property p_remove_clamp;
		q.evt_rem |-> q.clamp_active && !q.present;
	endproperty
	a_remove_clamp: assert property (p_remove_clamp) else $error("clamp off at removal"); // R23

	property p_override;
		q.clamp_ovd |-> q.clamp_active;
	endproperty
	a_override: assert property (p_override) else $error("override ignored"); // R26

	c_valid_discrete: cover property ($rose(q.valid) && q.mode == `AID_MODE_DISCRETE);
	c_valid_adc:      cover property ($rose(q.valid) && q.mode == `AID_MODE_ADC);
	c_removal:        cover property (q.evt_rem);
	c_settle:         cover property (q.state == AID_SETTLE ##1 q.state == AID_MEAS);

endmodule

// ===== core/aid_pkg.sv
/*
 Types for the accessory impedance detect controller.
 Assumes aid_defines.svh supplies all numeric constants except the state codes.
*/
package aid_pkg;

	typedef enum logic [2:0] {
		AID_IDLE   = 3'b000,
		AID_SETTLE = 3'b001,
		AID_MEAS   = 3'b010,
		AID_GAP    = 3'b011
	} aid_state_t;

	// From the analog measurement front end
	typedef struct packed {
		logic       done;
		logic [8:0] level;
		logic [6:0] adc;
	} aid_ana_in_t;

	// To the analog measurement front end
	typedef struct packed {
		logic       start;
		logic       bias_req;
		logic [2:0] ref_sel;
		logic [2:0] mode;
		logic       pin_b;
	} aid_ana_out_t;

	typedef struct packed {
		logic        pin_sel;
		logic [2:0]  mode;
		logic [3:0]  settle_code;
		logic [3:0]  rate_code;
		logic [2:0]  ref_sel;
		logic        db_sel;
		logic        ena;
		logic [7:0]  lvl_mask;
		logic        clamp_ovd;
		logic [3:0]  clamp_cond;
		logic [8:0]  level;
		logic        valid;
		logic        present;
		logic [6:0]  adc;
		logic [7:0]  adc_delta;
		logic        adc_seen;
		logic [8:0]  cand;
		logic [2:0]  db_cnt;
		aid_state_t  state;
		logic [12:0] pre;
		logic        tick;
		logic [14:0] dcnt;
		logic        start;
		logic        bias_req;
		logic        clamp_auto;
		logic        clamp_active;
		logic        evt_ins;
		logic        evt_rem;
		logic        evt_chg;
		logic [16:0] sync1;
		logic [16:0] sync2;
		logic        done_prev;
		logic        aw_have;
		logic [11:0] aw_addr;
		logic        w_have;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} aid_st_t;

endpackage

// ===== test/aid_front_model.sv
/*
 Behavioural analog front end for the detect controller.
 Assumes one aclk domain; answers each start DLY+1 cycles after it rises.
*/
`timescale 1ns/1ps

module aid_front_model
	import aid_pkg::*;
#(
	parameter int DLY = 20
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire aid_ana_out_t ana_o,
	input  wire logic [8:0]   level_i,
	input  wire logic [6:0]   adc_i,
	output aid_ana_in_t       ana_i
);
	// ---------------------------------------------
	// Measurement responder
	// ---------------------------------------------
	logic [7:0] cnt_q;

	// Results lead done; once done drops they stop holding
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= 8'h00;
			ana_i <= '0;
		end else if (ana_i.done) begin
			if (!ana_o.start) begin
				cnt_q       <= 8'h00;
				ana_i.done  <= 1'b0;
				ana_i.level <= ~ana_i.level;
				ana_i.adc   <= ~ana_i.adc;
			end
		end else if (ana_o.start) begin
			cnt_q <= cnt_q + 8'h01;
			if (cnt_q == 8'(DLY - 4)) begin
				ana_i.level <= level_i;
				ana_i.adc   <= adc_i;
			end
			if (cnt_q == 8'(DLY))
				ana_i.done <= 1'b1;
		end else begin
			cnt_q <= 8'h00;
		end
	end
endmodule

// ===== test/tb.sv
/*
 Self-checking bench for the detect controller over AXI4-Lite.
 Assumes TICK_DIV of 4 and the behavioural front end model.
*/
`timescale 1ns/1ps

module tb;
	import aid_pkg::*;
	logic        aclk, aresetn;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0]  s_axi_awprot, s_axi_arprot, bias_on_i;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, fb_pin_b, clamp_active, st_q;
	logic        evt_insert, evt_remove, evt_change, bias_seen;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb, clamp_condition_select;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [8:0]  lvl;
	logic [6:0]  adcb;
	logic [2:0]  codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
	aid_ana_in_t  ana_i;
	aid_ana_out_t ana_o;
	int err_count = 0, check_count = 0, n_meas = 0, n_ins = 0, n_rem = 0, n_chg = 0;
	int cyc = 0, t_fall = 0, gap = 0, m0, i;

	aid_detect_ctrl #(.TICK_DIV(4)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .ana_i, .bias_on_i, .ana_o, .fb_pin_b,
		.clamp_active, .clamp_condition_select, .evt_insert, .evt_remove, .evt_change);

	aid_front_model fe (.aclk, .aresetn, .ana_o, .level_i(lvl),
		.adc_i(adcb + 7'(n_meas)), .ana_i);

	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	// ---------------------------------------------
	// Monitors and helpers
	// ---------------------------------------------
	always @(posedge aclk) begin
		cyc   <= cyc + 1;
		st_q  <= ana_o.start;
		if (!aresetn) begin
			bias_seen <= 1'b0;
		end else begin
			n_ins <= n_ins + int'(evt_insert);
			n_rem <= n_rem + int'(evt_remove);
			n_chg <= n_chg + int'(evt_change);
			if (ana_o.bias_req === 1'b1)
				bias_seen <= 1'b1;
			if (st_q && !ana_o.start) begin
				n_meas <= n_meas + 1;
				t_fall <= cyc;
			end
			if (!st_q && ana_o.start)
				gap <= cyc - t_fall;
		end
	end

	task stop_test;
		if (err_count == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task hang(input int n);
		if (n > 200) begin
			err_count++;
			stop_test;
		end
	endtask

	task axw(input logic [11:0] a, input logic [31:0] v);
		logic ta, tw, tb_;
		logic [1:0] r;
		int n;
		n = 0;
		tb_ = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!tb_) begin
			@(negedge aclk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tb_ = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
			n++;
			hang(n);
		end
		s_axi_bready <= 1'b0;
		chk(r, 2'h0);
	endtask

	task axr(input logic [11:0] a, output logic [31:0] v, input logic [1:0] er);
		logic ta, tr;
		logic [1:0] r;
		int n;
		n = 0;
		tr = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!tr) begin
			@(negedge aclk);
			ta = s_axi_arvalid & s_axi_arready;
			tr = s_axi_rvalid;
			v = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ta)
				s_axi_arvalid <= 1'b0;
			n++;
			hang(n);
		end
		s_axi_rready <= 1'b0;
		chk(r, er);
	endtask

	task poll(input logic [31:0] m, input logic [31:0] e);
		for (int k = 0; k < 400; k++) begin
			axr(12'hA94, d, 2'h0);
			if ((d & m) === e)
				break;
		end
		chk(d & m, e);
		if ((d & m) !== e)
			stop_test;
	endtask

	// ---------------------------------------------
	// Main sequence
	// ---------------------------------------------
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awprot, s_axi_arprot, bias_on_i, adcb} = '0;
		s_axi_wstrb = 4'hF;
		lvl = 9'h008;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		axr(12'hA4C, d, 2'h0);
		chk(d, 32'h0000);  // mode resets discrete
		axr(12'hA8C, d, 2'h0);
		chk(d, 32'h1102);  // timing reset value
		axr(12'hA90, d, 2'h0);
		chk(d, 32'h009F);  // mask reset value
		axr(12'hB18, d, 2'h0);
		chk(d, 32'h0010);  // override set
		chk(clamp_active, 1'b1);  // clamp after reset
		axr(12'hA94, d, 2'h0);
		chk(d, 32'h0000);  // result cleared
		axr(12'hFFC, d, 2'h2);
		chk(d, 32'h0000);  // unmapped reads zero
		for (i = 0; i < 6; i++) begin
			axw(12'hA4C, 32'h2000 | codes[i]);
			@(negedge aclk);
			chk(ana_o.mode, codes[i]);  // mode code routed
		end
		chk({fb_pin_b, ana_o.pin_b}, 2'h3);  // second pin
		axw(12'hA4C, 32'h0000);  // idle in discrete
		@(negedge aclk);
		chk({fb_pin_b, ana_o.pin_b}, 2'h0);  // first pin
		axw(12'hA90, 32'h009B);  // bits six five zero
		axw(12'hB18, 32'h0000);  // release clamp first
		m0 = n_meas;
		axw(12'hA8C, 32'h1113);
		poll(32'hFFFF, 32'h0013);  // folded level valid
		chk(n_meas - m0, 4);  // four matches
		chk(n_ins, 1);  // insertion event
		chk(clamp_active, 1'b0);  // clamp released
		chk(ana_o.ref_sel, 3'h1);  // bias one reference
		chk(bias_seen, 1'b1);  // bias switched on
		chk(gap >= 60 && gap <= 76, 1'b1);  // gap plus settle
		axw(12'hB18, 32'h0015);  // override with condition
		@(negedge aclk);
		chk(clamp_active, 1'b1);  // override forces clamp
		chk(clamp_condition_select, 4'h5);  // condition stored
		axw(12'hB18, 32'h0000);  // clamp released again
		lvl <= 9'h020;
		poll(32'hFFFF, 32'h0083);  // level follows
		chk(n_chg, 1);  // change event
		lvl <= 9'h000;
		poll(32'hFFFF, 32'h0002);  // presence cleared
		chk(n_rem, 1);  // removal event
		chk(clamp_active, 1'b1);  // clamp on removal
		axw(12'hA8C, 32'h1112);
		axr(12'hA94, d, 2'h0);
		chk(d & 32'h2, 32'h0);  // valid drops
		axw(12'hA4C, 32'h0007);
		adcb = 7'h35 - 7'(n_meas);
		m0 = n_meas;
		axw(12'hA8C, 32'h1113);
		poll(32'h0002, 32'h0002);  // valid in ADC mode
		chk(n_meas - m0, 2);  // two measurements
		axw(12'hA8C, 32'h1112);  // disable before read
		axr(12'hAAC, d, 2'h0);
		chk(d, 32'h0136);  // value and delta
		axw(12'hA4C, 32'h0000);  // discrete mode, still disabled
		axw(12'hB18, 32'h0010);  // override back on
		@(negedge aclk);
		chk(clamp_active, 1'b1);  // override forces clamp
		stop_test;
	end
endmodule
